/* hw/uefec_pkg.sv */
// Constants for the USB error flag and endpoint control block.
// Assumes a 32-bit APB slave port with byte-address decode.
package uefec_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_ERR_STATUS = 12'h000;
	localparam logic [11:0] OFS_ERR_ENABLE = 12'h004;
	localparam logic [5:0]  EP_PAGE        = 6'h01;
	localparam logic [1:0]  WORD_ALIGN     = 2'h0;
	localparam logic [23:0] ZERO24         = 24'h000000;
	localparam logic [31:0] ZERO32         = 32'h00000000;

	// ----------------------------------------------------------------
	// Error status / enable bit positions
	// ----------------------------------------------------------------
	localparam int ERR_STUFF   = 7;
	localparam int ERR_OVERRUN = 5;
	localparam int ERR_TIMEOUT = 4;
	localparam int ERR_PARTIAL = 3;
	localparam int ERR_CRC16   = 2;
	localparam int ERR_TOK_EOF = 1;
	localparam int ERR_PID     = 0;
	localparam logic [7:0] ERR_IMPL_MASK = 8'hBF;
	localparam logic [7:0] ERR_RESET     = 8'h00;

	// ----------------------------------------------------------------
	// Endpoint control bit positions
	// ----------------------------------------------------------------
	localparam int EP_LOW_SPEED = 7;
	localparam int EP_RETRY_DIS = 6;
	localparam int EP_SETUP_DIS = 4;
	localparam int EP_RX_EN     = 3;
	localparam int EP_TX_EN     = 2;
	localparam int EP_STALLED   = 1;
	localparam int EP_HSHK_EN   = 0;
	localparam logic [7:0] EP_IMPL_MASK = 8'hDF;
	localparam logic [7:0] EP0_ONLY     = 8'hC0;
	localparam logic [7:0] EP_RESET     = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;

endpackage

/* hw/uefec_top.sv */
// USB error flags, error enable mask and sixteen endpoint controls.
// Assumes an APB master, and a packet engine that reports events as
// one-cycle pulses synchronous to REF_CLK.
//
// Behaviour
// - Bit stuff error sets sticky bit 7
// - Excess received bytes dropped, bit 5 set
// - Missing response in turnaround sets bit 4
// - Non-integral data field sets bit 3
// - Data CRC16 failure sets bit 2
// - Device mode: bad token CRC5 rejected, bit 1
// - Host mode: end-of-frame error sets bit 1
// - PID complement failure sets bit 0
// - Flags clear only by one writes with both low byte lanes strobed
// - Enable register masks each matching error flag
// - Summary flag raised only by enabled errors
// - Sixteen endpoint control registers, 0 to 15
// - Endpoint 0 bit 7 selects low-speed direct
// - Endpoint 0 bit 6 disables NAK retry
// - Bits 7,6 only endpoint 0, host mode
// - Both directions on: bit 4 refuses SETUP
// - Receive only while bit 3 set
// - Transmit only while bit 2 set
// - Bit 1 reports endpoint stalled
// - Handshakes only while bit 0 set
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/100ps

module uefec_top
	import uefec_pkg::*;
#(
	parameter int NUM_EP        = 16,
	parameter int BC_W          = 10,
	parameter int TURNAROUND_NS = 1000
) (
	// Clock and reset
	input  wire logic              REF_CLK,
	input  wire logic              RST_B,
	// APB slave
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [11:0]       PADDR,
	input  wire logic [31:0]       PWDATA,
	input  wire logic [3:0]        PSTRB,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	// Operating role
	input  wire logic              HOST_MODE,
	// Error event pulses from the packet engine
	input  wire logic              BIT_STUFF_ERR,
	input  wire logic              PARTIAL_BYTE_ERR,
	input  wire logic              CRC16_ERR,
	input  wire logic              EOF_ERR,
	input  wire logic              PID_ERR,
	// Receive byte path
	input  wire logic              RX_PKT_START,
	input  wire logic              RX_BYTE_VALID,
	input  wire logic [BC_W-1:0]   BD_BYTE_COUNT,
	output logic                   RX_BYTE_STORE,
	// Bus turnaround timing
	input  wire logic              TA_START,
	input  wire logic              RESP_START,
	// Token qualification
	input  wire logic              TOK_VALID,
	input  wire logic [3:0]        TOK_EP,
	input  wire logic              TOK_SETUP,
	input  wire logic              TOK_RX,
	input  wire logic              TOK_CRC5_BAD,
	output logic                   TOK_ACCEPT,
	output logic                   TOK_HANDSHAKE,
	// Stall report
	input  wire logic              STALL_EVENT,
	input  wire logic [3:0]        STALL_EP,
	// Host controls and summary
	output logic                   LOW_SPEED_DIRECT,
	output logic                   NAK_RETRY_EN,
	output logic                   ERROR_SUMMARY
);

	// ----------------------------------------------------------------
	// Derived timing
	// ----------------------------------------------------------------
	// Longest time rounds down to whole cycles, never below one
	localparam int TA_RAW    = TURNAROUND_NS / CLK_PERIOD_NS;
	localparam int TA_CYCLES = (TA_RAW < 1) ? 1 : TA_RAW;
	localparam logic [15:0] TA_LAST = 16'(TA_CYCLES - 1);
	localparam logic [15:0] TA_SPAN = 16'(TA_CYCLES);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0]      err_status;
	logic [7:0]      err_enable;
	logic [7:0]      ep_ctrl [NUM_EP];
	logic [7:0]      err_event;
	logic [BC_W-1:0] rx_count;
	logic            ta_busy;
	logic [15:0]     ta_count;
	logic            ta_expire;
	logic            overrun;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic       acc;
	logic       wr;
	logic       hit_status;
	logic       hit_enable;
	logic       hit_ep;
	logic [3:0] ep_idx;
	logic       full_word;

	// Zero wait states; read data is loaded in the setup cycle
	assign PREADY     = 1'b1;
	assign acc        = PSEL & PENABLE;
	assign wr         = acc & PWRITE;
	assign hit_status = (PADDR == OFS_ERR_STATUS);
	assign hit_enable = (PADDR == OFS_ERR_ENABLE);
	assign hit_ep     = (PADDR[11:6] == EP_PAGE) &
	                    (PADDR[1:0] == WORD_ALIGN);
	assign ep_idx     = PADDR[5:2];
	// Clears need both low lanes, so byte writes leave flags alone
	assign full_word  = &PSTRB[1:0];
	// Unmapped addresses answer with an error
	assign PSLVERR    = acc & ~(hit_status | hit_enable | hit_ep);

	// Visible endpoint value: bits 7,6 exist only on ep 0 in host mode
	function automatic logic [7:0] ep_view(input logic [3:0] idx);
		logic [7:0] v;
		v = ep_ctrl[idx] & EP_IMPL_MASK;
		if ((idx != 4'h0) || !HOST_MODE) begin
			v = v & ~EP0_ONLY;
		end
		return v;
	endfunction

	// Read data register, captured in the setup cycle
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			PRDATA <= ZERO32;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			if (hit_status) begin
				PRDATA <= {ZERO24, err_status & ERR_IMPL_MASK};
			end else if (hit_enable) begin
				PRDATA <= {ZERO24, err_enable & ERR_IMPL_MASK};
			end else if (hit_ep) begin
				PRDATA <= {ZERO24, ep_view(ep_idx)};
			end else begin
				PRDATA <= ZERO32;
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive byte limit
	// ----------------------------------------------------------------
	// store only bytes within the descriptor count
	assign RX_BYTE_STORE = RX_BYTE_VALID & (rx_count < BD_BYTE_COUNT);
	assign overrun       = RX_BYTE_VALID & ~RX_BYTE_STORE;

	// Count bytes of the current packet, saturating at the limit
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rx_count <= '0;
		end else if (RX_PKT_START) begin
			rx_count <= '0;
		end else if (RX_BYTE_STORE) begin
			rx_count <= rx_count + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Bus turnaround timer
	// ----------------------------------------------------------------
	// expiry without a response start is an error
	assign ta_expire = ta_busy & (ta_count == TA_LAST) & ~RESP_START;

	// Timer runs from TA_START until a response or expiry
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ta_busy  <= 1'b0;
			ta_count <= 16'h0000;
		end else if (TA_START) begin
			ta_busy  <= 1'b1;
			ta_count <= 16'h0000;
		end else if (RESP_START || ta_expire) begin
			ta_busy  <= 1'b0;
		end else if (ta_busy) begin
			ta_count <= ta_count + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Error event collection
	// ----------------------------------------------------------------
	always_comb begin
		err_event = 8'h00;
		err_event[ERR_STUFF]   = BIT_STUFF_ERR;
		err_event[ERR_OVERRUN] = overrun;
		err_event[ERR_TIMEOUT] = ta_expire;
		err_event[ERR_PARTIAL] = PARTIAL_BYTE_ERR;
		err_event[ERR_CRC16]   = CRC16_ERR;
		err_event[ERR_TOK_EOF] = HOST_MODE ? EOF_ERR
		                         : (TOK_VALID & TOK_CRC5_BAD);
		err_event[ERR_PID]     = PID_ERR;
	end

	// Sticky error flags
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			err_status <= ERR_RESET;
		end else begin
			if (wr && hit_status && full_word) begin
				err_status <= ((err_status & ~PWDATA[7:0]) | err_event)
				              & ERR_IMPL_MASK;
			end else begin
				err_status <= (err_status | err_event) & ERR_IMPL_MASK;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			err_enable <= ERR_RESET;
		end else if (wr && hit_enable && PSTRB[0]) begin
			err_enable <= PWDATA[7:0] & ERR_IMPL_MASK;
		end
	end

	assign ERROR_SUMMARY = |(err_status & err_enable & ERR_IMPL_MASK);

	// ----------------------------------------------------------------
	// Endpoint control registers
	// ----------------------------------------------------------------
	// one register per endpoint
	// stall report sets bit 1, winning over writes
	genvar g;
	generate
		for (g = 0; g < NUM_EP; g++) begin : g_ep
			logic [7:0] keep;
			// Bits 7,6 are not stored outside endpoint 0
			assign keep = (g == 0) ? EP_IMPL_MASK
			              : (EP_IMPL_MASK & ~EP0_ONLY);
			always_ff @(posedge REF_CLK or negedge RST_B) begin
				if (!RST_B) begin
					ep_ctrl[g] <= EP_RESET;
				end else begin
					if (wr && hit_ep && PSTRB[0] &&
					    (ep_idx == 4'(g))) begin
						ep_ctrl[g] <= (PWDATA[7:0] & keep) |
						  {6'h00, STALL_EVENT && (STALL_EP == 4'(g)), 1'b0};
					end else if (STALL_EVENT &&
					             (STALL_EP == 4'(g))) begin
						ep_ctrl[g][EP_STALLED] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Host controls from endpoint 0
	// ----------------------------------------------------------------
	// low-speed direct connect
	assign LOW_SPEED_DIRECT = HOST_MODE & ep_ctrl[0][EP_LOW_SPEED];
	assign NAK_RETRY_EN     = HOST_MODE & ~ep_ctrl[0][EP_RETRY_DIS];

	// ----------------------------------------------------------------
	// Token qualification
	// ----------------------------------------------------------------
	logic [7:0] tok_ep;
	logic       tok_both;
	logic       tok_dir_ok;
	logic       tok_crc_rej;

	always_comb begin
		tok_ep      = ep_ctrl[TOK_EP];
		tok_both    = tok_ep[EP_RX_EN] & tok_ep[EP_TX_EN];
		tok_crc_rej = ~HOST_MODE & TOK_CRC5_BAD;
		if (TOK_SETUP) begin
			// SETUP needs bit 3; bit 4 refuses it only with both on
			tok_dir_ok = tok_ep[EP_RX_EN] &
			             ~(tok_both & tok_ep[EP_SETUP_DIS]);
		end else if (TOK_RX) begin
			tok_dir_ok = tok_ep[EP_RX_EN];
		end else begin
			tok_dir_ok = tok_ep[EP_TX_EN];
		end
	end

	assign TOK_ACCEPT    = TOK_VALID & ~tok_crc_rej & tok_dir_ok;
	assign TOK_HANDSHAKE = TOK_ACCEPT & tok_ep[EP_HSHK_EN];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);

	// Full-word clear of the stuff flag, the only way it may drop
	logic ast_stuff_clr;
	assign ast_stuff_clr = wr & hit_status & full_word & PWDATA[ERR_STUFF];

	AST_STUFF_SET: assert property (
		BIT_STUFF_ERR |=> err_status[ERR_STUFF] ##1
		(err_status[ERR_STUFF] || $past(ast_stuff_clr)))
		else $error("stuff flag not held");

	AST_OVERRUN: assert property (
		RX_BYTE_VALID && !RX_PKT_START && rx_count >= BD_BYTE_COUNT
		|-> !RX_BYTE_STORE ##1 err_status[ERR_OVERRUN])
		else $error("excess byte stored or flag missing");

	// quiet span counter
	// Counts cycles since TA_START with no reply, apart from the timer
	logic [15:0] ast_quiet;
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ast_quiet <= 16'h0000;
		end else if (TA_START) begin
			ast_quiet <= 16'h0001;
		end else if (RESP_START || (ast_quiet == 16'h0000)) begin
			ast_quiet <= 16'h0000;
		end else begin
			ast_quiet <= ast_quiet + 16'h0001;
		end
	end

	AST_TIMEOUT: assert property (
		ast_quiet == TA_SPAN && !RESP_START && !TA_START
		|=> err_status[ERR_TIMEOUT])
		else $error("turnaround timeout not flagged");

	AST_PARTIAL: assert property (
		PARTIAL_BYTE_ERR |=> err_status[ERR_PARTIAL])
		else $error("partial byte flag missing");

	AST_CRC16: assert property (
		CRC16_ERR |=> err_status[ERR_CRC16])
		else $error("crc16 flag missing");

	AST_TOK_CRC: assert property (
		!HOST_MODE && TOK_VALID && TOK_CRC5_BAD
		|-> !TOK_ACCEPT ##1 err_status[ERR_TOK_EOF])
		else $error("bad token accepted or unflagged");

	AST_EOF: assert property (
		HOST_MODE && EOF_ERR |=> err_status[ERR_TOK_EOF])
		else $error("eof flag missing");

	AST_PID: assert property (
		PID_ERR |=> err_status[ERR_PID])
		else $error("pid flag missing");

	AST_PART_WRITE: assert property (
		wr && hit_status && !full_word && err_event == 8'h00
		|=> $stable(err_status))
		else $error("partial write changed flags");

	AST_CLEAR: assert property (
		wr && hit_status && full_word && PWDATA[ERR_PID] && PID_ERR
		|=> err_status[ERR_PID])
		else $error("clear beat a new event");

	AST_SUMMARY: assert property (
		err_enable == 8'h00 |-> !ERROR_SUMMARY)
		else $error("summary without enable");

	AST_EP_HIDDEN: assert property (
		PSEL && !PENABLE && !PWRITE && hit_ep && ep_idx != 4'h0
		|=> PRDATA[7:5] == 3'h0)
		else $error("host-only bits read nonzero");

	AST_SETUP_DIS: assert property (
		TOK_VALID && TOK_SETUP && tok_both && tok_ep[EP_SETUP_DIS]
		|-> !TOK_ACCEPT)
		else $error("setup accepted while disabled");

	AST_STALL: assert property (
		STALL_EVENT |=> ep_ctrl[$past(STALL_EP)][EP_STALLED])
		else $error("stall not reported");

	AST_HSHK: assert property (
		TOK_HANDSHAKE |-> TOK_ACCEPT && tok_ep[EP_HSHK_EN])
		else $error("handshake on disabled endpoint");

	COV_OVERRUN: cover property (overrun ##1 ERROR_SUMMARY);
	COV_TIMEOUT: cover property (ta_expire);
	COV_SETUP:   cover property (TOK_VALID && TOK_SETUP && TOK_ACCEPT);
	COV_CLEAR:   cover property (
		err_status != 8'h00 && wr && hit_status && full_word
		##1 err_status == 8'h00);

endmodule // uefec_top

/* verification/uefec_peer.sv */
// Packet engine stand-in: turns bench requests into error pulses.
// Assumes each request bit is raised for one REF_CLK cycle.
`timescale 1ns/100ps

module uefec_peer (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Requests: stuff, partial, crc16, eof, pid
	input  wire logic [4:0] req,
	// Error pulses toward the block
	output logic      [4:0] pulse
);
	// Registered so pulses never share the bench's drive edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			pulse <= 5'h00;
		else
			pulse <= req;
	end
endmodule // uefec_peer

/* verification/uefec_top_tb_top.sv */
// Self-checking bench for the error flag and endpoint control block.
// Assumes zero-wait APB and a packet engine model on the event lines.
`timescale 1ns/100ps

module uefec_top_tb_top;
	import uefec_pkg::*;
	// Short turnaround keeps the run brief
	localparam int TA_NS = 200;
	localparam int TA    = TA_NS / CLK_PERIOD_NS;
	logic        clk, rst_b, psel, pen, pwr, hm, rxs, rxv, tas, rss;
	logic        tv, tsu, trx, tbad, sev, rdy, serr, sto, acc, hsk;
	logic        lsd, nre, sum, se;
	logic [11:0] pa;
	logic [31:0] pwd, prd, r;
	logic [3:0]  pst, tep, sep;
	logic [9:0]  bc;
	logic [4:0]  req, pul;
	logic [7:0]  st, en, v;
	logic [7:0]  ep [16];
	int          err_total, n_checks, i, c, nb;
	int          bp [5] = '{ERR_STUFF, ERR_PARTIAL, ERR_CRC16,
		ERR_TOK_EOF, ERR_PID};

	uefec_peer i_peer (.clk(clk), .rst_b(rst_b), .req(req), .pulse(pul));
	uefec_top #(.TURNAROUND_NS(TA_NS)) i_dut (
		.REF_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(pst),
		.PRDATA(prd), .PREADY(rdy), .PSLVERR(serr), .HOST_MODE(hm),
		.BIT_STUFF_ERR(pul[4]), .PARTIAL_BYTE_ERR(pul[3]),
		.CRC16_ERR(pul[2]), .EOF_ERR(pul[1]), .PID_ERR(pul[0]),
		.RX_PKT_START(rxs), .RX_BYTE_VALID(rxv), .BD_BYTE_COUNT(bc),
		.RX_BYTE_STORE(sto), .TA_START(tas), .RESP_START(rss),
		.TOK_VALID(tv), .TOK_EP(tep), .TOK_SETUP(tsu), .TOK_RX(trx),
		.TOK_CRC5_BAD(tbad), .TOK_ACCEPT(acc), .TOK_HANDSHAKE(hsk),
		.STALL_EVENT(sev), .STALL_EP(sep), .LOW_SPEED_DIRECT(lsd),
		.NAK_RETRY_EN(nre), .ERROR_SUMMARY(sum));

	// Free-running 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #(CLK_PERIOD_NS / 2) clk = ~clk;
	end

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// One APB transfer; request held until PREADY is seen high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pen  <= 1'b0;
		pwr  <= w;
		pa   <= a;
		pwd  <= d;
		pst  <= s;
		@(posedge clk);
		pen <= 1'b1;
		// Wait for the answer; only the watchdog ends a hang
		do
			@(posedge clk);
		while (rdy !== 1'b1);
		r  = prd;
		se = serr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask

	// Write and mirror the effect in the model
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		apb(1'b1, a, d, s);
		if (a == OFS_ERR_STATUS && s[1:0] == 2'b11)
			st &= ~d[7:0];
		if (a == OFS_ERR_ENABLE && s[0])
			en = d[7:0] & ERR_IMPL_MASK;
		if (a[11:6] == EP_PAGE && s[0])
			ep[a[5:2]] = d[7:0] & EP_IMPL_MASK
				& (a[5:2] == 4'h0 ? 8'hFF : ~EP0_ONLY);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000, 4'h0);
		chk("read", r, e);
	endtask

	function automatic logic [11:0] epa(input int n);
		return {EP_PAGE, n[3:0], WORD_ALIGN};
	endfunction

	function automatic logic [7:0] epr(input int n);
		return ep[n] & (hm ? 8'hFF : ~EP0_ONLY);
	endfunction

	// Error requests through the peer; EOF only counts in host role
	task automatic ev(input logic [4:0] q);
		int j;
		@(posedge clk);
		req <= q;
		@(posedge clk);
		req <= 5'h00;
		for (j = 0; j < 5; j++)
			if (q[4 - j] && (bp[j] != ERR_TOK_EOF || hm))
				st[bp[j]] = 1'b1;
		@(posedge clk);
	endtask

	// Token on endpoint 3, looked at once outputs settle
	task automatic tok(input logic su, rx, bad, e);
		@(posedge clk);
		tv   <= 1'b1;
		tep  <= 4'h3;
		tsu  <= su;
		trx  <= rx;
		tbad <= bad;
		@(negedge clk);
		chk("accept", acc, e);
		chk("handshake", hsk, e & ep[3][EP_HSHK_EN]);
		@(posedge clk);
		tv <= 1'b0;
	endtask

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		{psel, pen, pwr, hm, rxs, rxv, tas, rss} = 8'h00;
		{tv, tsu, trx, tbad, sev} = 5'h00;
		{pa, pwd, pst, tep, sep, bc, req} = 71'h0;
		{st, en, err_total, n_checks} = 0;
		for (i = 0; i < 16; i++)
			ep[i] = EP_RESET;
		c = $urandom(32'h257d);
		rst_b = 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		rd(OFS_ERR_STATUS, ERR_RESET);
		rd(OFS_ERR_ENABLE, ERR_RESET);
		apb(1'b0, 12'h100, 32'h0, 4'h0);
		chk("slverr", se, 1'b1);
		// Each peer error source in host role, masked summary
		hm <= 1'b1;
		wr(OFS_ERR_ENABLE, $urandom & 32'hFF, 4'hF);
		rd(OFS_ERR_ENABLE, en);
		for (i = 0; i < 5; i++) begin
			ev(5'h10 >> i);
			rd(OFS_ERR_STATUS, st);
			chk("summary", sum, |(st & en));
		end
		// Single-byte strobe clears nothing, full word clears one
		wr(OFS_ERR_STATUS, 32'hFF, 4'h1);
		rd(OFS_ERR_STATUS, st);
		wr(OFS_ERR_STATUS, 32'h80, 4'hF);
		rd(OFS_ERR_STATUS, st);
		// Device role ignores EOF; the bad CRC5 token is tried after the token sweep
		wr(OFS_ERR_STATUS, 32'hFF, 4'hF);
		hm <= 1'b0;
		ev(5'h02);
		rd(OFS_ERR_STATUS, st);
		// Byte count overrun, back-to-back bytes
		nb = $urandom_range(6, 1);
		@(posedge clk);
		bc  <= nb[9:0];
		rxs <= 1'b1;
		@(posedge clk);
		rxs <= 1'b0;
		rxv <= 1'b1;
		for (i = 0; i < nb + 2; i++) begin
			@(negedge clk);
			chk("store", sto, i < nb);
			@(posedge clk);
		end
		rxv <= 1'b0;
		st[ERR_OVERRUN] = 1'b1;
		rd(OFS_ERR_STATUS, st);
		// Turnaround: reply in last cycle, then no reply
		wr(OFS_ERR_STATUS, 32'hFF, 4'hF);
		wr(OFS_ERR_ENABLE, 32'h10, 4'hF);
		@(posedge clk);
		tas <= 1'b1;
		@(posedge clk);
		tas <= 1'b0;
		repeat (TA - 1) @(posedge clk);
		rss <= 1'b1;
		@(posedge clk);
		rss <= 1'b0;
		repeat (TA + 2) @(posedge clk);
		chk("no timeout", sum, 1'b0);
		tas <= 1'b1;
		for (i = 1; i <= TA + 1; i++) begin
			@(posedge clk);
			tas <= 1'b0;
			@(negedge clk);
			chk("timeout", sum, i == TA + 1);
		end
		st[ERR_TIMEOUT] = 1'b1;
		// Endpoint registers with random contents, host role
		hm <= 1'b1;
		for (i = 0; i < 16; i++)
			wr(epa(i), $urandom, 4'hF);
		for (i = 0; i < 16; i++)
			rd(epa(i), epr(i));
		chk("low speed", lsd, ep[0][EP_LOW_SPEED]);
		chk("retry", nre, !ep[0][EP_RETRY_DIS]);
		hm <= 1'b0;
		// Let the role change land before the model reads it
		@(posedge clk);
		rd(epa(0), epr(0));
		chk("dev low speed", lsd, 1'b0);
		chk("dev retry", nre, 1'b0);
		// Stall report sets bit 1
		wr(epa(5), 32'h00, 4'hF);
		@(posedge clk);
		sev <= 1'b1;
		sep <= 4'h5;
		@(posedge clk);
		sev <= 1'b0;
		ep[5][EP_STALLED] = 1'b1;
		rd(epa(5), epr(5));
		// Every enable combination against each token kind
		for (c = 0; c < 16; c++) begin
			v = {3'h0, c[3], c[2], c[1], 1'b0, c[0]};
			wr(epa(3), v, 4'hF);
			tok(1'b1, 1'b0, 1'b0, v[3] & !(v[3] & v[2] & v[4]));
			tok(1'b0, 1'b1, 1'b0, v[3]);
			tok(1'b0, 1'b0, 1'b0, v[2]);
		end
		tok(1'b0, 1'b1, 1'b1, 1'b0);
		st[ERR_TOK_EOF] = 1'b1;
		rd(OFS_ERR_STATUS, st);
		end_of_test();
	end

	// Hang guard, far beyond the expected run length
	initial begin
		#(20000 * CLK_PERIOD_NS);
		err_total++;
		end_of_test();
	end
endmodule // uefec_top_tb_top
